// *** logic/irq_ctrl_pkg.sv ***
package irq_ctrl_pkg;
   localparam int NUM_SRC = 16;
   // register offsets (plain port address space)
   localparam logic [7:0] INTERRUPT_ENABLE_OFFSET = 8'hA8;
   localparam logic [7:0] TIMER_EXT_IRQ_CONTROL_OFFSET = 8'h88;
   localparam logic [7:0] EXT_IRQ_CONTROL_OFFSET = 8'hC0;
   localparam logic [7:0] EXT_ENABLE_1_OFFSET = 8'hAD;
   localparam logic [7:0] EXT_ENABLE_2_OFFSET = 8'hA5;
   localparam logic [7:0] PRIO_LOW_0_OFFSET = 8'hB8;
   localparam logic [7:0] PRIO_HIGH_0_OFFSET = 8'hB7;
   localparam logic [7:0] PRIO_LOW_1_OFFSET = 8'hAE;
   localparam logic [7:0] PRIO_HIGH_1_OFFSET = 8'hAF;
   localparam logic [7:0] PRIO_LOW_2_OFFSET = 8'hF8;
   localparam logic [7:0] PRIO_HIGH_2_OFFSET = 8'hF7;
   localparam logic [7:0] AUX_CONTROL_0_OFFSET = 8'hA1;
   localparam logic [7:0] PENDING_LOW_OFFSET = 8'hE0;
   localparam logic [7:0] PENDING_HIGH_OFFSET = 8'hE1;
   localparam logic [7:0] STATUS_OFFSET = 8'hE2;
   // field positions
   localparam int GLOBAL_EN_BIT = 7;
   localparam int IE_RESERVED_BIT = 6;
   localparam int TC_IE1_BIT = 3;
   localparam int TC_IT1_BIT = 2;
   localparam int TC_IE0_BIT = 1;
   localparam int TC_IT0_BIT = 0;
   localparam int XC_POL3_BIT = 7;
   localparam int XC_EN3_BIT = 6;
   localparam int XC_FLAG3_BIT = 5;
   localparam int XC_TYPE3_BIT = 4;
   localparam int XC_POL2_BIT = 3;
   localparam int XC_EN2_BIT = 2;
   localparam int XC_FLAG2_BIT = 1;
   localparam int XC_TYPE2_BIT = 0;
   localparam int AUX_POL0_BIT = 0;
   localparam int AUX_POL1_BIT = 1;
   // source indices, 0-based, in polling order
   localparam int SRC_EXT0 = 0;
   localparam int SRC_TMR0 = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_TMR1 = 3;
   localparam int SRC_EXT2 = 6;
   localparam int SRC_EXT3 = 7;
   // priority patterns {high,low}
   localparam logic [1:0] PRIO_LEVEL1 = 2'h3;
   localparam logic [1:0] PRIO_LEVEL4 = 2'h0;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   typedef enum logic [2:0] {
      ST_RUN = 3'h1,
      ST_HOLD = 3'h2,
      ST_CALL = 3'h4
   } vec_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic last_cycle;
      logic return_from_interrupt;
      logic power_down;
   } cpu_status_t;

   typedef struct packed {
      logic [7:0] irq_en;
      logic [7:0] timer_ext_irq_control;
      logic [7:0] ext_irq_control_reg;
      logic [7:0] ext_enable_reg_1;
      logic ext_enable_reg_2;
      logic [7:0] pl0;
      logic [7:0] ph0;
      logic [7:0] pl1;
      logic [7:0] ph1;
      logic pl2;
      logic ph2;
      logic [1:0] aux;
      logic [3:0] ext_prev;
      logic [NUM_SRC-1:0] sample;
      logic [3:0] active;
      logic hold;
      vec_state_t state;
      logic call;
      logic [3:0] vec_idx;
      logic [7:0] rdata;
   } ctrl_state_t;
endpackage

// *** logic/four_level_interrupt_controller.sv ***
`timescale 1ns/1ps
// How it works
// - global enable cleared suppresses every call regardless of source enables; wake ignores it
// - with global enable set, each source gated by its own enable bit
// - enables: main register bits 0-5, extended 1 bits 0-6, extended 2 bit 0, control
// - two-bit priority high/low; 11 highest level, 00 lowest level
// - lower-level request never preempts a running higher-level routine
// - simultaneous different levels: higher level vectored first
// - equal level: fixed polling order, source 1 first, source 16 last
// - flags sampled each cycle, polled next cycle, call issued unless blocked
// - call withheld while equal or higher level is in service
// - call only on final cycle of the current instruction
// - after return or a write to enable, extended enable 1 or priority 0/1 registers, one instruction runs before vectoring
// - in power-down, edge-configured external inputs act level-sensitive
// - polarity bits of inputs 2 and 3: set high/rising, clear low/falling
// - inputs 0,1: type 0 level, type 1 edge; polarity bit picks sense
// - external 0/1 flags set on detection, auto-cleared on entry if edge
// - external 0-3 flags settable and clearable by software; peripheral flags come in on periph_flag, pending registers read-only
// - peripheral flags other than timers 0/1 and external not cleared on vectoring
// - in idle/power-down, inputs 2/3 set flag and wake only when enabled
module four_level_interrupt_controller
   import irq_ctrl_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst_n, // async reset
   input wire reg_req_t req, // register port request
   output logic [7:0] rdata, // read data, one cycle after strobe
   input wire cpu_status_t cpu, // core status
   input wire logic idle, // core in idle mode
   input wire logic [3:0] ext_in, // external pins ext_irq_input_0..3
   input wire logic [NUM_SRC-1:0] periph_flag, // peripheral flags (ext entries unused)
   output logic [NUM_SRC-1:0] hw_clear, // pulse: clear timer 0/1 flag on entry
   output logic call, // hardware_long_call pulse
   output logic [3:0] vec_idx, // vectored source index
   output logic wake // wake request for idle/power-down
);
   ctrl_state_t s_reg, s_next;
   logic [NUM_SRC-1:0] flags, en, ph, pl;
   logic [1:0] lvl [NUM_SRC];
   logic [3:0] ext_level_hit, ext_edge_hit, ext_detect, ext_type, ext_pol;
   logic [NUM_SRC-1:0] bidder;
   logic [1:0] best_lvl;
   logic [3:0] best_idx;
   logic found, cfg_write;

   // per-source enables, priority bits and hardware flags
   always_comb begin
      en = {s_reg.ext_enable_reg_2, s_reg.ext_enable_reg_1[6:0], s_reg.ext_irq_control_reg[XC_EN3_BIT], s_reg.ext_irq_control_reg[XC_EN2_BIT], s_reg.irq_en[5:0]};
      pl = {s_reg.pl2, s_reg.pl1[6:0], s_reg.pl0[7:6], s_reg.pl0[5:0]};
      ph = {s_reg.ph2, s_reg.ph1[6:0], s_reg.ph0[7:6], s_reg.ph0[5:0]};
      flags = periph_flag;
      flags[SRC_EXT0] = s_reg.timer_ext_irq_control[TC_IE0_BIT];
      flags[SRC_EXT1] = s_reg.timer_ext_irq_control[TC_IE1_BIT];
      flags[SRC_EXT2] = s_reg.ext_irq_control_reg[XC_FLAG2_BIT];
      flags[SRC_EXT3] = s_reg.ext_irq_control_reg[XC_FLAG3_BIT];
      ext_type = {s_reg.ext_irq_control_reg[XC_TYPE3_BIT], s_reg.ext_irq_control_reg[XC_TYPE2_BIT],
                  s_reg.timer_ext_irq_control[TC_IT1_BIT], s_reg.timer_ext_irq_control[TC_IT0_BIT]};
      ext_pol = {s_reg.ext_irq_control_reg[XC_POL3_BIT], s_reg.ext_irq_control_reg[XC_POL2_BIT], s_reg.aux};
   end

   // detection per input; power-down forces level mode since no edges may be seen
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ext
         assign ext_level_hit[g] = ext_in[g] == ext_pol[g];
         assign ext_edge_hit[g] = (ext_in[g] == ext_pol[g]) && (s_reg.ext_prev[g] != ext_pol[g]);
         assign ext_detect[g] = (ext_type[g] && !cpu.power_down) ? ext_edge_hit[g] : ext_level_hit[g];
      end
      for (g = 0; g < NUM_SRC; g++) begin : g_lvl
         assign lvl[g] = {ph[g], pl[g]};
         assign bidder[g] = s_reg.sample[g] && en[g] && s_reg.irq_en[GLOBAL_EN_BIT];
      end
   endgenerate

   // best bidder: higher level wins, ties resolved by lowest index
   always_comb begin
      best_lvl = PRIO_LEVEL4;
      best_idx = 4'h0;
      found = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (bidder[i] && (!found || lvl[i] > best_lvl)) begin
            found = 1'b1;
            best_lvl = lvl[i];
            best_idx = 4'(i);
         end
      end
   end

   assign cfg_write = req.wr && (req.addr == INTERRUPT_ENABLE_OFFSET || req.addr == EXT_ENABLE_1_OFFSET ||
      req.addr == PRIO_LOW_0_OFFSET || req.addr == PRIO_HIGH_0_OFFSET ||
      req.addr == PRIO_LOW_1_OFFSET || req.addr == PRIO_HIGH_1_OFFSET);

   // next-state logic: register writes, flag updates, vectoring
   always_comb begin
      logic [3:0] higher;
      logic block;
      higher = 4'h0;
      block = 1'b0;
      s_next = s_reg;
      s_next.call = 1'b0;
      s_next.ext_prev = ext_in;
      s_next.sample = flags;
      // register writes
      if (req.wr) begin
         case (req.addr)
            INTERRUPT_ENABLE_OFFSET: s_next.irq_en = req.wdata;
            TIMER_EXT_IRQ_CONTROL_OFFSET: s_next.timer_ext_irq_control = req.wdata;
            EXT_IRQ_CONTROL_OFFSET: s_next.ext_irq_control_reg = req.wdata;
            EXT_ENABLE_1_OFFSET: s_next.ext_enable_reg_1 = {1'b0, req.wdata[6:0]};
            EXT_ENABLE_2_OFFSET: s_next.ext_enable_reg_2 = req.wdata[0];
            PRIO_LOW_0_OFFSET: s_next.pl0 = req.wdata;
            PRIO_HIGH_0_OFFSET: s_next.ph0 = req.wdata;
            PRIO_LOW_1_OFFSET: s_next.pl1 = {1'b0, req.wdata[6:0]};
            PRIO_HIGH_1_OFFSET: s_next.ph1 = {1'b0, req.wdata[6:0]};
            PRIO_LOW_2_OFFSET: s_next.pl2 = req.wdata[0];
            PRIO_HIGH_2_OFFSET: s_next.ph2 = req.wdata[0];
            AUX_CONTROL_0_OFFSET: s_next.aux = req.wdata[1:0];
            default: ;
         endcase
      end
      // auto-clear of edge flags on entry, before hardware set so a new edge wins
      if (s_reg.call) begin
         if (s_reg.vec_idx == 4'(SRC_EXT0) && s_reg.timer_ext_irq_control[TC_IT0_BIT])
            s_next.timer_ext_irq_control[TC_IE0_BIT] = 1'b0;
         if (s_reg.vec_idx == 4'(SRC_EXT1) && s_reg.timer_ext_irq_control[TC_IT1_BIT])
            s_next.timer_ext_irq_control[TC_IE1_BIT] = 1'b0;
         if (s_reg.vec_idx == 4'(SRC_EXT2) && s_reg.ext_irq_control_reg[XC_TYPE2_BIT])
            s_next.ext_irq_control_reg[XC_FLAG2_BIT] = 1'b0;
         if (s_reg.vec_idx == 4'(SRC_EXT3) && s_reg.ext_irq_control_reg[XC_TYPE3_BIT])
            s_next.ext_irq_control_reg[XC_FLAG3_BIT] = 1'b0;
      end
      // level mode: flag follows the pin, cleared only by the source going inactive
      for (int k = 0; k < 2; k++) begin
         if (ext_detect[k])
            s_next.timer_ext_irq_control[k == 0 ? TC_IE0_BIT : TC_IE1_BIT] = 1'b1;
         else if (!ext_type[k] && !(req.wr && req.addr == TIMER_EXT_IRQ_CONTROL_OFFSET))
            s_next.timer_ext_irq_control[k == 0 ? TC_IE0_BIT : TC_IE1_BIT] = 1'b0;
      end
      // inputs 2 and 3 only set their flag in low power when enabled
      if (ext_detect[2] && (!(idle || cpu.power_down) || s_reg.ext_irq_control_reg[XC_EN2_BIT]))
         s_next.ext_irq_control_reg[XC_FLAG2_BIT] = 1'b1;
      if (ext_detect[3] && (!(idle || cpu.power_down) || s_reg.ext_irq_control_reg[XC_EN3_BIT]))
         s_next.ext_irq_control_reg[XC_FLAG3_BIT] = 1'b1;
      // return from interrupt releases the highest level in progress
      if (cpu.return_from_interrupt) begin
         if (s_reg.active[3]) s_next.active[3] = 1'b0;
         else if (s_reg.active[2]) s_next.active[2] = 1'b0;
         else if (s_reg.active[1]) s_next.active[1] = 1'b0;
         else s_next.active[0] = 1'b0;
      end
      // block condition 3 holds until an instruction has completed
      if (cfg_write || cpu.return_from_interrupt)
         s_next.hold = 1'b1;
      else if (cpu.last_cycle && s_reg.state == ST_HOLD)
         s_next.hold = 1'b0;
      for (int l = 0; l < 4; l++) begin
         if (l >= int'(best_lvl) && s_reg.active[l])
            higher[l] = 1'b1;
      end
      block = (|higher) || !cpu.last_cycle || s_reg.hold || cfg_write || cpu.return_from_interrupt;
      case (s_reg.state)
         ST_RUN: begin
            if (s_reg.hold) s_next.state = ST_HOLD;
            else if (found && !block) begin
               s_next.call = 1'b1;
               s_next.vec_idx = best_idx;
               s_next.active[best_lvl] = 1'b1;
               s_next.state = ST_CALL;
            end
         end
         ST_HOLD: begin
            if (!s_next.hold) s_next.state = ST_RUN;
         end
         ST_CALL: s_next.state = ST_RUN; // one call per entry
         default: s_next.state = ST_RUN;
      endcase
      if (s_reg.hold && s_reg.state == ST_RUN) s_next.state = ST_HOLD;
      // read data
      s_next.rdata = RESET_BYTE;
      if (req.rd) begin
         case (req.addr)
            INTERRUPT_ENABLE_OFFSET: s_next.rdata = s_reg.irq_en & ~(8'h01 << IE_RESERVED_BIT);
            TIMER_EXT_IRQ_CONTROL_OFFSET: s_next.rdata = s_reg.timer_ext_irq_control;
            EXT_IRQ_CONTROL_OFFSET: s_next.rdata = s_reg.ext_irq_control_reg;
            EXT_ENABLE_1_OFFSET: s_next.rdata = s_reg.ext_enable_reg_1;
            EXT_ENABLE_2_OFFSET: s_next.rdata = {7'h00, s_reg.ext_enable_reg_2};
            PRIO_LOW_0_OFFSET: s_next.rdata = s_reg.pl0;
            PRIO_HIGH_0_OFFSET: s_next.rdata = s_reg.ph0;
            PRIO_LOW_1_OFFSET: s_next.rdata = s_reg.pl1;
            PRIO_HIGH_1_OFFSET: s_next.rdata = s_reg.ph1;
            PRIO_LOW_2_OFFSET: s_next.rdata = {7'h00, s_reg.pl2};
            PRIO_HIGH_2_OFFSET: s_next.rdata = {7'h00, s_reg.ph2};
            AUX_CONTROL_0_OFFSET: s_next.rdata = {6'h00, s_reg.aux};
            PENDING_LOW_OFFSET: s_next.rdata = s_reg.sample[7:0];
            PENDING_HIGH_OFFSET: s_next.rdata = s_reg.sample[15:8];
            STATUS_OFFSET: s_next.rdata = {s_reg.active, s_reg.vec_idx};
            default: s_next.rdata = RESET_BYTE;
         endcase
      end
   end

   // single state register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.state <= ST_RUN;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs; the clear pulse lets peripherals drop timer 0/1 flags on entry
   always_comb begin
      hw_clear = '0;
      if (s_reg.call && (s_reg.vec_idx == 4'(SRC_TMR0) || s_reg.vec_idx == 4'(SRC_TMR1)))
         hw_clear[s_reg.vec_idx] = 1'b1;
   end
   assign call = s_reg.call;
   assign vec_idx = s_reg.vec_idx;
   assign rdata = s_reg.rdata;
   assign wake = |(s_reg.sample & en);
endmodule

// *** bench/irq_ctrl_chk.sv ***
`timescale 1ns/1ps
// port-level watch over call timing and flag clears
module irq_ctrl_chk
   import irq_ctrl_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst_n, // async reset
   input wire reg_req_t req, // register port
   input wire cpu_status_t cpu, // core status
   input wire logic [NUM_SRC-1:0] hw_clear, // clear pulses
   input wire logic call, // hardware call
   input wire logic [3:0] vec_idx // vectored source
);
   logic ga_reg;
   // shadow of the global enable, so a call is judged without looking inside
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         ga_reg <= 1'b0;
      else if (req.wr && req.addr == INTERRUPT_ENABLE_OFFSET)
         ga_reg <= req.wdata[GLOBAL_EN_BIT];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_call_needs_global: assert property (call |-> ga_reg) else $error("call while disabled");
   a_call_single: assert property (call |=> !call) else $error("call longer than one cycle");
   a_call_last_cycle: assert property (call |-> $past(cpu.last_cycle)) else $error("call mid-instruction");
   a_return_from_interrupt_holds: assert property (cpu.return_from_interrupt |=> !call [*2]) else $error("call right after return");
   a_write_holds: assert property (req.wr && (req.addr == INTERRUPT_ENABLE_OFFSET ||
      req.addr == PRIO_LOW_0_OFFSET) |=> !call [*2]) else $error("call right after write");
   a_clear_timers: assert property (hw_clear != 16'h0000 |-> (hw_clear & 16'hFFF5) == 16'h0000)
      else $error("clear on software-cleared flag");
   a_clear_on_entry: assert property (hw_clear != 16'h0000 |-> call || $past(call))
      else $error("clear without entry");
   a_idx_on_call: assert property ($changed(vec_idx) |-> call) else $error("index moved without call");
endmodule
bind four_level_interrupt_controller irq_ctrl_chk chk_inst (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
   .cpu(cpu), .hw_clear(hw_clear), .call(call), .vec_idx(vec_idx));

// *** bench/cpu_model.sv ***
`timescale 1ns/1ps
// core stand-in: marks instruction ends and returns from service
module cpu_model
   import irq_ctrl_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst_n, // async reset
   input wire logic call, // hardware call
   input wire logic slow, // three-cycle instructions
   input wire logic auto_ret, // return after short routine
   input wire logic ret_now, // bench-commanded return
   input wire logic pd_in, // power-down level from the bench
   output cpu_status_t cpu // status to controller
);
   logic [1:0] ph_reg;
   logic [3:0] svc_reg;
   logic fire;
   // a return only lands on an instruction's final cycle
   assign fire = (ret_now || (auto_ret && svc_reg == 4'h1)) && (!slow || ph_reg == 2'h1);
   // instruction phase and service countdown
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_reg <= 2'h0;
         svc_reg <= 4'h0;
         cpu <= '0;
      end else begin
         ph_reg <= (!slow || ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
         cpu.last_cycle <= !slow || ph_reg == 2'h1;
         svc_reg <= call ? 4'h6 : (fire ? 4'h0 : svc_reg - {3'h0, svc_reg > 4'h1});
         cpu.return_from_interrupt <= fire;
         cpu.power_down <= pd_in;
      end
   end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
// drives registers and source flags, checks which source is called
module tb_top
   import irq_ctrl_pkg::*;
;
   typedef struct packed {
      logic [7:0] ie;
      logic [7:0] e1;
      logic e2;
      logic [15:0] fl;
      logic hit;
      logic [3:0] idx;
   } row_t;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   reg_req_t req = '0;
   cpu_status_t cpu;
   logic [15:0] flag = 16'h0000;
   logic [3:0] ext = 4'hF;
   logic slow = 1'b1;
   logic aret = 1'b1;
   logic ret_now = 1'b0;
   logic idle = 1'b0;
   logic pd = 1'b0;
   logic [7:0] rdata;
   logic [15:0] hw_clear;
   logic call, hit, wake;
   logic [3:0] vec_idx, idx;
   int err_total = 0;
   int compares = 0;
   // enables, flags, expected call; all sources at the lowest level
   row_t rows [8] = '{
      '{8'h82, 8'h00, 1'b0, 16'h0002, 1'b1, 4'h1},
      '{8'h02, 8'h00, 1'b0, 16'h0002, 1'b0, 4'h0},
      '{8'h80, 8'h00, 1'b0, 16'h002A, 1'b0, 4'h0},
      '{8'hAA, 8'h00, 1'b0, 16'h002A, 1'b1, 4'h1},
      '{8'hA8, 8'h00, 1'b0, 16'h0038, 1'b1, 4'h3},
      '{8'h80, 8'h40, 1'b0, 16'h4100, 1'b1, 4'hE},
      '{8'h80, 8'h01, 1'b1, 16'h8100, 1'b1, 4'h8},
      '{8'h80, 8'h00, 1'b1, 16'h8000, 1'b1, 4'hF}};
   four_level_interrupt_controller DUT (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
      .cpu(cpu), .idle(idle), .ext_in(ext), .periph_flag(flag), .hw_clear(hw_clear), .call(call),
      .vec_idx(vec_idx), .wake(wake));
   cpu_model core (.ref_clk(ref_clk), .rst_n(rst_n), .call(call), .slow(slow), .auto_ret(aret),
      .ret_now(ret_now), .pd_in(pd), .cpu(cpu));
   always #5 ref_clk = ~ref_clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // strobes drop for a cycle between accesses so no signal is set twice at one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge ref_clk);
      req.wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, exp});
      @(posedge ref_clk);
   endtask
   task automatic expect_call(input logic h, input logic [3:0] i);
      hit = 1'b0;
      for (int n = 0; n < 40 && !hit; n++) begin
         @(posedge ref_clk);
         #1;
         if (call === 1'b1) begin
            hit = 1'b1;
            idx = vec_idx;
         end
      end
      @(posedge ref_clk);
      chk({15'h0000, hit}, {15'h0000, h});
      if (h)
         chk({12'h000, idx}, {12'h000, i});
   endtask
   task automatic ret();
      ret_now <= 1'b1;
      @(posedge ref_clk);
      ret_now <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic stop_test();
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd(INTERRUPT_ENABLE_OFFSET, 8'h00);
      rd(8'h00, 8'h00);
      foreach (rows[i]) begin
         wr(EXT_ENABLE_1_OFFSET, rows[i].e1);
         wr(EXT_ENABLE_2_OFFSET, {7'h00, rows[i].e2});
         wr(INTERRUPT_ENABLE_OFFSET, rows[i].ie);
         flag <= rows[i].fl;
         expect_call(rows[i].hit, rows[i].idx);
         flag <= 16'h0000;
         repeat (20) @(posedge ref_clk);
      end
      // timer 1 at the top level, timer 0 left at the bottom
      slow <= 1'b0;
      aret <= 1'b0;
      wr(PRIO_HIGH_0_OFFSET, 8'h08);
      wr(PRIO_LOW_0_OFFSET, 8'h08);
      wr(INTERRUPT_ENABLE_OFFSET, 8'h8A);
      flag <= 16'h000A;
      expect_call(1'b1, 4'h3);
      flag <= 16'h0002;
      expect_call(1'b0, 4'h0);
      ret();
      expect_call(1'b1, 4'h1);
      flag <= 16'h0000;
      ret();
      // software-set edge flag on input 2, then a real falling edge
      wr(EXT_IRQ_CONTROL_OFFSET, 8'h07);
      expect_call(1'b1, 4'h6);
      ret();
      expect_call(1'b0, 4'h0);
      ext[2] <= 1'b0;
      expect_call(1'b1, 4'h6);
      ret();
      wr(AUX_CONTROL_0_OFFSET, 8'h01);
      wr(INTERRUPT_ENABLE_OFFSET, 8'h81);
      expect_call(1'b1, 4'h0);
      rd(PENDING_LOW_OFFSET, 8'h01);
      rd(STATUS_OFFSET, 8'h10);
      // idle: a disabled input 2 neither flags nor wakes, an enabled one does both
      wr(INTERRUPT_ENABLE_OFFSET, 8'h00);
      ret();
      idle <= 1'b1;
      wr(EXT_IRQ_CONTROL_OFFSET, 8'h01);
      ext[2] <= 1'b1;
      @(posedge ref_clk);
      ext[2] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(EXT_IRQ_CONTROL_OFFSET, 8'h01);
      #1;
      chk({15'h0000, wake}, 16'h0000);
      @(posedge ref_clk);
      wr(EXT_IRQ_CONTROL_OFFSET, 8'h05);
      ext[2] <= 1'b1;
      @(posedge ref_clk);
      ext[2] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(EXT_IRQ_CONTROL_OFFSET, 8'h07);
      #1;
      chk({15'h0000, wake}, 16'h0001);
      @(posedge ref_clk);
      // power-down turns the edge-configured input 2, held low, into a level input
      idle <= 1'b0;
      wr(EXT_IRQ_CONTROL_OFFSET, 8'h05);
      rd(EXT_IRQ_CONTROL_OFFSET, 8'h05);
      pd <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(EXT_IRQ_CONTROL_OFFSET, 8'h07);
      pd <= 1'b0;
      stop_test();
   end
   // hang guard, well beyond the several hundred cycles the sequence needs
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_total++;
      stop_test();
   end
endmodule
